// ### verif/didfs_checker.sv
// Assertion checker for the debounced input block
`timescale 1ns/1ps
`default_nettype none
module didfs_checker
  import didfs_pkg::*;
#(
  parameter int N_IN = 4,
  parameter int CW   = 32
) (
  input wire logic              i_clock,
  input wire logic              i_rst,
  input wire logic [N_IN-1:0]   i_status_pin,
  input wire logic [N_IN-1:0]   i_meter_assign,
  input wire logic [N_IN-1:0]   o_state,
  input wire logic [2*N_IN-1:0] o_control_mode,
  input wire logic [N_IN-1:0]   o_associated,
  input wire logic [CW*N_IN-1:0] o_pulse_count,
  input wire logic [N_IN-1:0]   o_alarm_state,
  input wire logic              o_demand_sync,
  input wire logic [N_IN-1:0]   o_tariff_state
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  chk_mode_meter: assert property ($past(i_meter_assign[3], 2)
    |-> o_control_mode[7:6] == 2'h2) else $error("meter mode");
  chk_assoc_meter: assert property ($past(i_meter_assign[3], 3)
    |-> o_associated[3]) else $error("association");
  chk_state_hold: assert property ($changed(o_state[0])
    |-> o_state[0] == $past(i_status_pin[0], 3)) else $error("state");
  chk_count_rise: assert property ($rose(o_state[0]) |->
    o_pulse_count[CW-1:0] == $past(o_pulse_count[CW-1:0]) + 1)
    else $error("count step");
  chk_count_idle: assert property (!$rose(o_state[0])
    |-> $stable(o_pulse_count[CW-1:0])) else $error("count idle");
  chk_sync_rise: assert property (o_demand_sync
    |-> $rose(o_state[0])) else $error("sync cause");
  chk_sync_once: assert property (o_demand_sync
    |=> !o_demand_sync) else $error("sync width");
  chk_alarm_level: assert property (o_alarm_state[1]
    |-> o_state[1] || $past(o_state[1])) else $error("alarm");
  chk_tariff_level: assert property (o_tariff_state[2]
    |-> o_state[2] || $past(o_state[2])) else $error("tariff");
endmodule
bind didfs_top didfs_checker #(.N_IN(N_IN), .CW(CW)) chk (
  .i_clock(i_clock), .i_rst(i_rst), .i_status_pin(i_status_pin),
  .i_meter_assign(i_meter_assign), .o_state(o_state),
  .o_control_mode(o_control_mode), .o_associated(o_associated),
  .o_pulse_count(o_pulse_count), .o_alarm_state(o_alarm_state),
  .o_demand_sync(o_demand_sync), .o_tariff_state(o_tariff_state));
`default_nettype wire

// ### verif/didfs_contact.sv
// Model of a contact that chatters before it settles
`timescale 1ns/1ps
`default_nettype none
module didfs_contact #(
  parameter int CHATTER = 0
) (
  input  wire logic i_clock,
  input  wire logic i_level,
  output var logic  o_pin
);
  logic prev = 1'b0;
  int   left = 0;
  initial o_pin = 1'b0;
  // Each level change with nonzero CHATTER toggles the pin CHATTER+1 cycles before settling
  always @(posedge i_clock) begin
    prev <= i_level;
    if (i_level != prev) left <= CHATTER;
    else if (left > 0) left <= left - 1;
    o_pin <= ((i_level != prev && CHATTER > 0) || left > 0) ? ~o_pin : i_level;
  end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the debounced input block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import didfs_pkg::*;
;
  logic         i_clock = 1'b0;
  logic         i_rst = 1'b1;
  logic [3:0]   lvl = 4'h0, pin, st, asc, alst, tst;
  logic [27:0]  deb = {7'h01, 7'h00, 7'h02, 7'h00};
  logic [3:0]   alarm = 4'h0, dem = 4'h0, tar = 4'h0, met = 4'h0, tmod = 4'h0;
  logic         dmode = 1'b0, tmode = 1'b0, dsync;
  logic [7:0]   cm;
  logic [127:0] pc, cc;
  int           err_count = 0, tests_run = 0;
  initial forever #2 i_clock = ~i_clock;
  for (genvar k = 0; k < 4; k++) begin : g_ct
    didfs_contact #(.CHATTER(k == 1 ? 20 : 0)) ct (
      .i_clock(i_clock), .i_level(lvl[k]), .o_pin(pin[k]));
  end
  didfs_top #(.TICK_CYC(10)) dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_status_pin(pin),
    .i_debounce_code(deb), .i_alarm_link(alarm), .i_demand_assign(dem),
    .i_demand_input_mode(dmode), .i_tariff_assign(tar),
    .i_tariff_input_mode(tmode), .i_meter_chan_sel(8'h00),
    .i_meter_assign(met), .i_chan_transition_mode(tmod), .o_state(st),
    .o_control_mode(cm), .o_associated(asc), .o_pulse_count(pc),
    .o_alarm_state(alst), .o_demand_sync(dsync), .o_tariff_state(tst),
    .o_chan_count(cc));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic drv(input int k, input logic v);
    @(posedge i_clock);
    lvl[k] <= v;
  endtask
  task automatic test_done;
    $display("errors=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic t_cfg;
    @(posedge i_clock);
    dem <= 4'h1; alarm <= 4'h2; tar <= 4'h4; met <= 4'h8; tmode <= 1'b1;
    cyc(4);
    chk(cm, 8'hB0);
    @(posedge i_clock);
    dmode <= 1'b1;
    cyc(4);
    chk(cm, 8'hB1);
    chk(asc, 4'hF);
  endtask
  task automatic t_zero;
    int n = 0;
    drv(0, 1'b1);
    repeat (8) begin
      cyc(1);
      if (dsync === 1'b1) n++;
    end
    chk(st[0], 1);
    chk(n, 1);
    drv(0, 1'b0);
    cyc(8);
    chk(pc[31:0], 1);
  endtask
  task automatic t_bounce;
    drv(1, 1'b1);
    cyc(100);
    drv(1, 1'b0);
    cyc(300);
    chk(pc[63:32], 0);
    drv(1, 1'b1);
    cyc(150);
    chk(st[1], 0);
    cyc(100);
    chk(st[1], 1);
    chk(alst[1], 1);
  endtask
  task automatic t_chan;
    repeat (2) begin
      drv(3, 1'b1);
      cyc(130);
      drv(3, 1'b0);
      cyc(130);
      @(posedge i_clock);
      tmod <= 4'h1;
    end
    chk(cc[31:0], 3);
    chk(pc[127:96], 2);
    drv(2, 1'b1);
    cyc(8);
    chk(tst, 4'h4);
  endtask
  initial begin
    #40000;
    err_count++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    cyc(2);
    t_cfg;
    t_zero;
    t_bounce;
    t_chan;
    test_done;
  end
endmodule
`default_nettype wire

// ### verilog/didfs_defs.svh
// Constants for the debounced digital input block
`ifndef DIDFS_DEFS_SVH
`define DIDFS_DEFS_SVH
`define DIDFS_CLK_KHZ       250000
`define DIDFS_TICK_MS       1
`define DIDFS_TICK_CYC      (`DIDFS_CLK_KHZ * `DIDFS_TICK_MS)
`define DIDFS_DEB_STEP_MS   10
`define DIDFS_DEB_MAX_MS    1000
`define DIDFS_DEB_MAX_CODE  (`DIDFS_DEB_MAX_MS / `DIDFS_DEB_STEP_MS)
`define DIDFS_NUM_INPUTS    4
`define DIDFS_NUM_CHANNELS  4
`define DIDFS_COUNT_W       32
`define DIDFS_DEB_RST       7'h00
`define DIDFS_MODE_RST      2'h0
`endif

// ### verilog/didfs_pkg.sv
// Types for the debounced digital input block
package didfs_pkg;
  typedef enum logic [1:0] {
    DIDFS_MODE_NORMAL = 2'b00,
    DIDFS_MODE_DEMAND = 2'b01,
    DIDFS_MODE_METER  = 2'b10,
    DIDFS_MODE_TARIFF = 2'b11
  } didfs_mode_t;
endpackage

// ### verilog/didfs_top.sv
// Debounced digital status inputs with function select
// Notes on behaviour
// RULE1 - Debounce time per input is 0 to 1000 ms in 10 ms steps.
// RULE2 - A new level counts only after it holds for the full debounce time.
// RULE3 - Each input shows a two-bit control mode selecting its consumer.
// RULE4 - Normal mode counts every valid pulse independently.
// RULE5 - Normal mode may feed the validated level to an input alarm.
// RULE6 - Demand mode pulses align the demand interval start.
// RULE7 - Demand follows an input only when its own mode is input-driven.
// RULE8 - Metering mode counts valid pulses for the assigned channel.
// RULE9 - Assigning an input to a channel puts it in metering mode.
// RULE10 - Tariff mode delivers the validated level to tariff selection.
// RULE11 - A read-only association output shows which function uses an input.
// RULE12 - Each channel counts per full pulse or per level transition.
// RULE13 - Up to four inputs, each with its own filter and mode.
// RULE14 - Debounce of zero passes each sampled change immediately.
// RULE15 - Counters step once per validated off-to-on transition on ms tick; with a debounce of zero they step without waiting for ms_tick.
`timescale 1ns/1ps
`default_nettype none
`include "didfs_defs.svh"

module didfs_top
  import didfs_pkg::*;
#(
  parameter int N_IN     = `DIDFS_NUM_INPUTS,
  parameter int N_CH     = `DIDFS_NUM_CHANNELS,
  parameter int CW       = `DIDFS_COUNT_W,
  parameter int TICK_CYC = `DIDFS_TICK_CYC
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic [N_IN-1:0]   i_status_pin,
  input  wire logic [7*N_IN-1:0] i_debounce_code,
  input  wire logic [N_IN-1:0]   i_alarm_link,
  input  wire logic [N_IN-1:0]   i_demand_assign,
  input  wire logic              i_demand_input_mode,
  input  wire logic [N_IN-1:0]   i_tariff_assign,
  input  wire logic              i_tariff_input_mode,
  input  wire logic [2*N_IN-1:0] i_meter_chan_sel,
  input  wire logic [N_IN-1:0]   i_meter_assign,
  input  wire logic [N_CH-1:0]   i_chan_transition_mode,
  output logic [N_IN-1:0]        o_state,
  output logic [2*N_IN-1:0]      o_control_mode,
  output logic [N_IN-1:0]        o_associated,
  output logic [CW*N_IN-1:0]     o_pulse_count,
  output logic [N_IN-1:0]        o_alarm_state,
  output logic                   o_demand_sync,
  output logic [N_IN-1:0]        o_tariff_state,
  output logic [CW*N_CH-1:0]     o_chan_count
);

  // ****************************************
  // Millisecond tick
  // ****************************************
  logic [31:0] tick_cnt;
  logic        ms_tick;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt <= 32'h0;
    end else if (tick_cnt == 32'(TICK_CYC - 1)) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ms_tick <= 1'b0;
    end else if (tick_cnt == 32'(TICK_CYC - 1)) begin
      ms_tick <= 1'b1; // RULE15
    end else begin
      ms_tick <= 1'b0;
    end
  end

  // ****************************************
  // Per input filter, mode and counters
  // ****************************************
  logic [N_IN-1:0] rise;
  logic [N_IN-1:0] edge_any;
  logic [N_IN-1:0] sync_demand;
  logic [N_IN-1:0] is_meter;

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in // RULE13
      logic        meta;
      logic        samp;
      logic        stable;
      logic [9:0]  hold_ms;
      logic [10:0] limit_ms;
      logic [6:0]  code;
      didfs_mode_t mode;
      didfs_mode_t next_mode;

      // ****************************************
      // Debounce limit
      // ****************************************

      // Codes above the top step clamp to 1000 ms
      assign code = (i_debounce_code[7*gi +: 7] > 7'(`DIDFS_DEB_MAX_CODE))
                  ? 7'(`DIDFS_DEB_MAX_CODE)
                  : i_debounce_code[7*gi +: 7]; // RULE1
      assign limit_ms = 11'(code) * 11'(`DIDFS_DEB_STEP_MS); // RULE1

      // ****************************************
      // Pin synchroniser
      // ****************************************

      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          meta <= 1'b0;
          samp <= 1'b0;
        end else begin
          meta <= i_status_pin[gi];
          samp <= meta;
        end
      end

      // ****************************************
      // Debounce filter
      // ****************************************

      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          stable  <= 1'b0;
          hold_ms <= 10'h000;
        end else if (samp == stable) begin
          hold_ms <= 10'h000; // RULE2
        end else if (limit_ms == 11'h000) begin
          stable  <= samp; // RULE14
          hold_ms <= 10'h000;
        end else if (ms_tick) begin
          if ({1'b0, hold_ms} + 11'h001 >= limit_ms) begin
            stable  <= samp; // RULE2
            hold_ms <= 10'h000;
          end else begin
            hold_ms <= hold_ms + 10'h001;
          end
        end
      end

      // ****************************************
      // Edge detect
      // ****************************************

      logic stable_d;
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          stable_d <= 1'b0;
        end else begin
          stable_d <= stable;
        end
      end
      assign rise[gi]     = stable & ~stable_d; // RULE15
      assign edge_any[gi] = stable ^ stable_d;

      // ****************************************
      // Mode select
      // ****************************************

      // Metering takes priority, then demand, tariff, else normal
      always_comb begin
        if (i_meter_assign[gi]) begin
          next_mode = DIDFS_MODE_METER; // RULE9
        end else if (i_demand_assign[gi] && i_demand_input_mode) begin
          next_mode = DIDFS_MODE_DEMAND; // RULE7
        end else if (i_tariff_assign[gi] && i_tariff_input_mode) begin
          next_mode = DIDFS_MODE_TARIFF;
        end else begin
          next_mode = DIDFS_MODE_NORMAL;
        end
      end

      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          mode <= DIDFS_MODE_NORMAL;
        end else begin
          mode <= next_mode;
        end
      end

      // ****************************************
      // Status outputs
      // ****************************************

      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          o_control_mode[2*gi +: 2] <= `DIDFS_MODE_RST;
        end else begin
          o_control_mode[2*gi +: 2] <= mode; // RULE3
        end
      end

      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          o_associated[gi] <= 1'b0;
        end else begin
          o_associated[gi] <= (mode != DIDFS_MODE_NORMAL)
                            || i_alarm_link[gi]; // RULE11
        end
      end

      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          o_state[gi] <= 1'b0;
        end else begin
          o_state[gi] <= stable;
        end
      end

      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          o_alarm_state[gi] <= 1'b0;
        end else begin
          o_alarm_state[gi] <= (mode == DIDFS_MODE_NORMAL)
                             && i_alarm_link[gi] && stable; // RULE5
        end
      end

      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          o_tariff_state[gi] <= 1'b0;
        end else begin
          o_tariff_state[gi] <= (mode == DIDFS_MODE_TARIFF)
                              && stable; // RULE10
        end
      end

      // ****************************************
      // Pulse counter
      // ****************************************

      // Pulse counter runs in every mode
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          o_pulse_count[CW*gi +: CW] <= '0;
        end else if (rise[gi]) begin
          o_pulse_count[CW*gi +: CW] <=
            o_pulse_count[CW*gi +: CW] + CW'(1); // RULE4
        end
      end

      assign sync_demand[gi] = rise[gi] && (mode == DIDFS_MODE_DEMAND);
      assign is_meter[gi]    = (mode == DIDFS_MODE_METER);
    end
  endgenerate

  // ****************************************
  // Demand synchronisation pulse
  // ****************************************
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_demand_sync <= 1'b0;
    end else begin
      o_demand_sync <= |sync_demand; // RULE6
    end
  end

  // ****************************************
  // Metering channel counters
  // ****************************************
  genvar gc;
  generate
    for (gc = 0; gc < N_CH; gc++) begin : g_ch
      logic [CW-1:0] inc;

      // ****************************************
      // Channel increment
      // ****************************************

      always_comb begin
        inc = '0;
        for (int k = 0; k < N_IN; k++) begin
          if (is_meter[k]
              && i_meter_chan_sel[2*k +: 2] == 2'(gc)) begin
            if (i_chan_transition_mode[gc]) begin
              inc = inc + CW'(edge_any[k]); // RULE12
            end else begin
              inc = inc + CW'(rise[k]); // RULE8
            end
          end
        end
      end

      // ****************************************
      // Channel accumulator
      // ****************************************

      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          o_chan_count[CW*gc +: CW] <= '0;
        end else begin
          o_chan_count[CW*gc +: CW] <=
            o_chan_count[CW*gc +: CW] + inc; // RULE8
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire
